// File: hdl/intc_vector_map.v
/*
 * interrupt priority selection, vector assignment and vector table
 * fetch, with avalon-mm access to the priority and status registers.
 * assumes request inputs are already sensed and synchronous to clk,
 * and that the core raises core_accept for one cycle to take a request.
 */
`timescale 1ns/100ps
`default_nettype none
`include "intc_map_defs.vh"

module intc_vector_map (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire nmi_request,
    input wire break_match,
    input wire [3:0] ext_request,
    input wire [`N_PERIPH-1:0] periph_request,
    output wire irq_to_core,
    output wire [4:0] irq_level,
    input wire core_accept,
    output reg [`N_SRC-1:0] source_ack,
    output reg [7:0] accepted_vector,
    output reg [31:0] vector_addr,
    output reg vt_read,
    input wire [31:0] vt_rdata,
    input wire vt_valid,
    output reg [31:0] handler_addr,
    output reg handler_valid,
    output reg [3:0] interrupt_mask_level
);

    // ************************************************************
    // merge of a 16-bit register with the two low byte lanes
    // ************************************************************
    function [15:0] lane_merge;
        input [15:0] old;
        input [31:0] wdata;
        input [3:0] be;
        begin
            lane_merge = old;
            if (be[0])
            begin
                lane_merge[7:0] = wdata[7:0];
            end
            if (be[1])
            begin
                lane_merge[15:8] = wdata[15:8];
            end
        end
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    localparam [`N_SRC*8-1:0] VEC_TBL = `VEC_TABLE;
    localparam [`N_SRC*8-1:0] FLD_TBL = `FLD_TABLE;
    localparam [1:0] S_IDLE = `ST_IDLE;
    localparam [1:0] S_FETCH = `ST_FETCH;

    reg [15:0] prio_reg [0:`PRIO_COUNT-1];
    wire [`PRIO_COUNT*16-1:0] prio_flat;
    wire [`N_SRC*4-1:0] lvl_flat;
    wire [`N_SRC-1:0] src_req;
    reg nmi_prev_reg;
    reg brk_prev_reg;
    reg nmi_pend_reg;
    reg brk_pend_reg;
    reg bus_ack_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [4:0] best_lvl;
    reg [7:0] best_vec;
    reg [5:0] best_idx;
    reg best_nmi;
    reg best_brk;
    reg best_prog;
    reg [3:0] cand_lvl;
    integer k;
    wire take;
    wire bus_wr;
    wire bus_rd;
    wire status_wr;

    assign src_req = {periph_request, ext_request};

    // ************************************************************
    // per-source level lookup
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `PRIO_COUNT; g = g + 1)
        begin : g_flat
            assign prio_flat[g*16 +: 16] = prio_reg[g];
        end
        for (g = 0; g < `N_SRC; g = g + 1)
        begin : g_lvl
            localparam [7:0] FC = FLD_TBL[g*8 +: 8];
            // field chosen by register and nibble code
            // sources sharing a field share one level
            assign lvl_flat[g*4 +: 4] =
                prio_flat[FC[7:2]*16 + FC[1:0]*4 +: 4];
        end
    endgenerate

    // ************************************************************
    // selection of the highest request
    // ************************************************************
    always @*
    begin
        best_lvl = 5'h00;
        best_vec = 8'h00;
        best_idx = 6'h00;
        best_nmi = 1'b0;
        best_brk = 1'b0;
        best_prog = 1'b0;
        cand_lvl = 4'h0;
        // nmi at level 16 outranks everything
        if (nmi_pend_reg)
        begin
            best_lvl = `LVL_NMI;
            best_vec = `VEC_NMI;
            best_nmi = 1'b1;
        end
        // user break at fixed level 15
        else if (brk_pend_reg)
        begin
            best_lvl = `LVL_BREAK;
            best_vec = `VEC_BREAK;
            best_brk = 1'b1;
        end
        // scan in vector order, strict compare keeps lower vector
        for (k = 0; k < `N_SRC; k = k + 1)
        begin
            cand_lvl = lvl_flat[k*4 +: 4];
            // level 0 never beats the empty start value
            if (src_req[k] && ({1'b0, cand_lvl} > best_lvl))
            begin
                best_lvl = {1'b0, cand_lvl};
                // distinct vector per source from the table
                best_vec = VEC_TBL[k*8 +: 8];
                best_idx = k[5:0];
                best_nmi = 1'b0;
                best_brk = 1'b0;
                best_prog = 1'b1;
            end
        end
    end

    // forward only when strictly above the current mask
    assign irq_to_core = (state_reg == S_IDLE) &&
        (best_lvl != 5'h00) &&
        (best_lvl > {1'b0, interrupt_mask_level});
    assign irq_level = best_lvl;
    assign take = irq_to_core && core_accept;

    // ************************************************************
    // avalon-mm slave: one wait state on every access
    // ************************************************************
    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_reg;
    assign bus_wr = avs_write && bus_ack_reg;
    assign bus_rd = avs_read && !bus_ack_reg;
    assign status_wr = bus_wr && (avs_address == `IDX_STATUS);

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_ack_reg <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            bus_ack_reg <= (avs_read || avs_write) && !bus_ack_reg;
            if (bus_rd)
            begin
                if (avs_address <= `IDX_PRIO_LAST)
                begin
                    avs_readdata <= {16'h0000, prio_reg[avs_address]};
                end
                else if (avs_address == `IDX_STATUS)
                begin
                    avs_readdata <= {16'h0000, accepted_vector, 3'b000,
                        irq_to_core, interrupt_mask_level};
                end
                else
                begin
                    // unmapped words read as zero
                    avs_readdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ************************************************************
    // priority registers
    // ************************************************************
    generate
        for (g = 0; g < `PRIO_COUNT; g = g + 1)
        begin : g_prio
            always @(posedge clk)
            begin
                if (sys_rst)
                begin
                    prio_reg[g] <= `PRIO_RST;
                end
                // full 4-bit level per field, 0 to 15
                else if (bus_wr && (avs_address == g))
                begin
                    prio_reg[g] <= lane_merge(prio_reg[g],
                        avs_writedata, avs_byteenable);
                end
            end
        end
    endgenerate

    // ************************************************************
    // edge detection and pending flags
    // ************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            nmi_prev_reg <= 1'b0;
            brk_prev_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            brk_pend_reg <= 1'b0;
        end
        else
        begin
            nmi_prev_reg <= nmi_request;
            brk_prev_reg <= break_match;
            // a new edge in the accept cycle stays pending
            nmi_pend_reg <= (nmi_request && !nmi_prev_reg) ||
                (nmi_pend_reg && !(take && best_nmi));
            // rising edge sets, acceptance clears, set wins
            brk_pend_reg <= (break_match && !brk_prev_reg) ||
                (brk_pend_reg && !(take && best_brk));
        end
    end

    // ************************************************************
    // acceptance: vector, table address, mask update
    // ************************************************************
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            source_ack <= {`N_SRC{1'b0}};
            accepted_vector <= 8'h00;
            vector_addr <= 32'h0000_0000;
            interrupt_mask_level <= `MASK_RST;
        end
        else
        begin
            source_ack <= {`N_SRC{1'b0}};
            if (take)
            begin
                accepted_vector <= best_vec;
                vector_addr <= {22'h00_0000, best_vec, 2'b00};
                if (best_prog)
                begin
                    source_ack[best_idx] <= 1'b1;
                    interrupt_mask_level <= best_lvl[3:0];
                end
                else
                begin
                    // break and nmi both leave the mask at 15
                    interrupt_mask_level <= `MASK_AFTER_FIXED;
                end
            end
            else if (status_wr && avs_byteenable[0])
            begin
                interrupt_mask_level <= avs_writedata[3:0];
            end
        end
    end

    // ************************************************************
    // vector table fetch
    // ************************************************************
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE:
            begin
                if (take)
                begin
                    state_next = S_FETCH;
                end
            end
            S_FETCH:
            begin
                if (vt_valid)
                begin
                    state_next = S_IDLE;
                end
            end
            default:
            begin
                state_next = S_IDLE;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= S_IDLE;
            vt_read <= 1'b0;
            handler_addr <= 32'h0000_0000;
            handler_valid <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            handler_valid <= 1'b0;
            // read the entry that vector_addr points at
            vt_read <= (state_next == S_FETCH);
            if ((state_reg == S_FETCH) && vt_valid)
            begin
                handler_addr <= vt_rdata;
                handler_valid <= 1'b1;
            end
        end
    end

    // a new request waits while a fetch is open, so the vector and
    // table address stay stable for the whole read

endmodule // intc_vector_map
`default_nettype wire

// File: inc/intc_map_defs.vh
/*
 * constants of the interrupt priority and vector map: register word
 * indices, field layout, reset values, fixed levels and vectors, and
 * the packed per-source vector and priority field tables.
 * assumes it is included by bare name from the design file and the checker.
 */
`ifndef INTC_MAP_DEFS_VH
`define INTC_MAP_DEFS_VH

// register word indices (byte address = index * 4)
`define IDX_PRIO_FIRST 4'h0
`define IDX_PRIO_LAST 4'h8
`define IDX_STATUS 4'h9
`define PRIO_COUNT 9
`define PRIO_RST 16'h0000

// status word layout
`define ST_MASK_LSB 0
`define ST_PEND_BIT 4
`define ST_VEC_LSB 8
`define MASK_RST 4'hf

// fixed sources
`define LVL_NMI 5'h10
`define LVL_BREAK 5'h0f
`define MASK_AFTER_FIXED 4'hf
`define VEC_NMI 8'h0b
`define VEC_BREAK 8'h0c

// programmable sources: index 0..3 pins, 4..45 peripherals
`define N_SRC 46
`define N_PERIPH 42

// vector number per source, source 0 in the low byte
`define VEC_TABLE {32'hc8b8_b5b4, \
    48'hafae_adac_abaa, 48'ha9a8_9c98_9490, \
    48'h8c89_887c_7b7a, 48'h7978_7473_7271, \
    48'h706d_6c69_6865, 48'h6461_605c_5b5a, \
    48'h5958_4342_4140}

// field code per source: [7:2] register, [1:0] nibble (3 = bits 15:12)
`define FLD_TABLE {32'h231f_1818, \
    48'h1a1a_1a1a_1b1b, 48'h1b1b_1617_1011, \
    48'h1213_130e_0f0f, 48'h0f0f_0809_0909, \
    48'h090a_0a0b_0b04, 48'h0405_0506_0707, \
    48'h0707_0001_0203}

// fetch state codes, one-hot
`define ST_IDLE 2'b01
`define ST_FETCH 2'b10

`endif

// File: tb/intc_map_props.sv
/*
 * checker for the interrupt vector map, bound to its top ports.
 * assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "intc_map_defs.vh"
// ****************
// acceptance rules
// ****************
module intc_map_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irq_to_core,
    input wire logic [4:0] irq_level,
    input wire logic core_accept,
    input wire logic [`N_SRC-1:0] source_ack,
    input wire logic [7:0] accepted_vector,
    input wire logic [31:0] vector_addr,
    input wire logic vt_read,
    input wire logic vt_valid,
    input wire logic [31:0] vt_rdata,
    input wire logic [31:0] handler_addr,
    input wire logic handler_valid,
    input wire logic [3:0] interrupt_mask_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire take = irq_to_core && core_accept;
    chk_above_mask: assert property (
        irq_to_core |-> irq_level > {1'b0, interrupt_mask_level})
        else $error("request not above mask");
    chk_nmi_take: assert property (
        take && irq_level == 5'h10 |=>
        accepted_vector == 8'h0b && interrupt_mask_level == 4'hf)
        else $error("nmi acceptance wrong");
    chk_break_mask: assert property (
        take |=> accepted_vector != 8'h0c || interrupt_mask_level == 4'hf)
        else $error("break mask wrong");
    chk_table_addr: assert property (
        take |=> vector_addr == {22'h0, accepted_vector, 2'b00})
        else $error("vector address wrong");
    chk_mask_load: assert property (
        take && irq_level < 5'h10 |=>
        {1'b0, interrupt_mask_level} == $past(irq_level))
        else $error("mask not loaded with level");
    chk_fetch_result: assert property (
        vt_read && vt_valid |=>
        handler_valid && !vt_read && handler_addr == $past(vt_rdata))
        else $error("handler address wrong");
    chk_fetch_open: assert property (
        take |=> vt_read && !irq_to_core)
        else $error("fetch did not open");
    chk_ack_single: assert property (
        take |=> $onehot0(source_ack) ##1 source_ack == '0)
        else $error("source ack not single");
    cover property (take && irq_level == 5'h10);
    cover property (take && irq_level == 5'h0f);
    cover property (take && irq_level < 5'h0f);
endmodule // intc_map_props
bind intc_vector_map intc_map_props u_intc_map_props (.clk, .sys_rst,
    .irq_to_core, .irq_level, .core_accept, .source_ack, .accepted_vector,
    .vector_addr, .vt_read, .vt_valid, .vt_rdata, .handler_addr,
    .handler_valid, .interrupt_mask_level);
`default_nettype wire

// File: tb/core_model.sv
/*
 * processor core stand-in: takes requests and serves the vector table.
 * assumes the map's registered fetch handshake on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
// **************
// core and table
// **************
module core_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic accept_en,
    input wire logic [3:0] latency,
    input wire logic irq_to_core,
    input wire logic vt_read,
    input wire logic [31:0] vector_addr,
    output var logic core_accept,
    output var logic vt_valid,
    output var logic [31:0] vt_rdata
);
    logic [3:0] wait_reg;
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            core_accept <= 1'b0;
            vt_valid <= 1'b0;
            vt_rdata <= 32'h0000_0000;
            wait_reg <= 4'h0;
        end
        else
        begin
            // pulse only, so one request is never taken twice
            core_accept <= accept_en && irq_to_core && !core_accept;
            vt_valid <= 1'b0;
            // data off the bus is never left looking valid
            vt_rdata <= ~vt_rdata;
            if (vt_read && !vt_valid)
            begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg == latency)
                begin
                    vt_valid <= 1'b1;
                    vt_rdata <= 32'h0a00_0000 + vector_addr;
                    wait_reg <= 4'h0;
                end
            end
        end
    end
endmodule // core_model
`default_nettype wire

// File: tb/testbench.sv
/*
 * self-checking bench: register access, priority order, fixed sources.
 * assumes the core model above and the map's one-wait bus answer.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("MISMATCH %s expected %h seen %h", what, exp, got); \
        end \
    end
// *********
// the bench
// *********
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h3;
    logic nmi_request = 1'b0;
    logic break_match = 1'b0;
    logic accept_en = 1'b0;
    logic [3:0] latency = 4'h0;
    logic [45:0] src_hold = '0;
    logic [45:0] src_set = '0;
    wire [3:0] ext_request;
    wire [41:0] periph_request;
    wire [31:0] avs_readdata, vector_addr, vt_rdata, handler_addr;
    wire avs_waitrequest, irq_to_core, core_accept, vt_read, vt_valid;
    wire handler_valid;
    wire [4:0] irq_level;
    wire [45:0] source_ack;
    wire [7:0] accepted_vector;
    wire [3:0] interrupt_mask_level;
    int num_errors = 0;
    int checks_done = 0;
    assign ext_request = src_hold[3:0];
    assign periph_request = src_hold[45:4];
    always #10 clk = ~clk;
    // sources hold their request until acknowledged
    always @(posedge clk) src_hold <= (src_hold & ~source_ack) | src_set;
    intc_vector_map u_intc_vector_map (.clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .nmi_request, .break_match,
        .ext_request, .periph_request, .irq_to_core, .irq_level,
        .core_accept, .source_ack, .accepted_vector, .vector_addr,
        .vt_read, .vt_rdata, .vt_valid, .handler_addr, .handler_valid,
        .interrupt_mask_level);
    core_model u_core_model (.clk, .sys_rst, .accept_en, .latency,
        .irq_to_core, .vt_read, .vector_addr, .core_accept, .vt_valid,
        .vt_rdata);
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic timeout;
        num_errors++;
        conclude();
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic bus(input logic wr, input logic [3:0] idx,
        input logic [31:0] wd, output logic [31:0] rd);
        int i;
        logic ok;
        ok = 1'b0;
        @(posedge clk);
        avs_address <= idx;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest and readdata are read as they stood at the edge
        for (i = 0; i < 20 && !ok; i++)
        begin
            @(posedge clk);
            ok = (avs_waitrequest === 1'b0);
            rd = avs_readdata;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!ok) timeout();
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask
    task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0000_0000, rd);
        `CHK("readdata", exp, rd)
    endtask
    task automatic raise(input logic [45:0] m);
        @(posedge clk);
        src_set <= m;
        @(posedge clk);
        src_set <= '0;
    endtask
    task automatic wait_take(input logic [7:0] vec, input logic [3:0] lvl);
        int i;
        for (i = 0; i < 60 && handler_valid !== 1'b1; i++) @(negedge clk);
        if (handler_valid !== 1'b1) timeout();
        `CHK("vector", vec, accepted_vector)
        `CHK("handler", 32'h0a00_0000 + {22'h0, vec, 2'b00}, handler_addr)
        `CHK("mask", lvl, interrupt_mask_level)
    endtask
    task automatic take_seq(input int v0, input int dir, input int l0,
        input int ls, input int n);
        int i;
        @(posedge clk);
        accept_en <= 1'b1;
        for (i = 0; i < n; i++)
        begin
            wait_take(8'(v0 + dir * i), 4'(l0 + ls * i));
            tick(3);
            `CHK("blocked", 1'b0, irq_to_core)
            wr(4'h9, 32'h0000_0000);
        end
    endtask
    task automatic scen_regs;
        int i;
        for (i = 0; i < 9; i++) rd_chk(4'(i), 32'h0000_0000);
        rd_chk(4'h9, 32'h0000_000f);
        for (i = 0; i < 9; i++) wr(4'(i), 32'hffff_f731 + 32'(i));
        for (i = 0; i < 9; i++) rd_chk(4'(i), 32'h0000_f731 + 32'(i));
        wr(4'ha, 32'h0000_1234);
        rd_chk(4'ha, 32'h0000_0000);
    endtask
    task automatic scen_pins;
        wr(4'h0, 32'h0000_1234);
        wr(4'h9, 32'h0000_0000);
        accept_en <= 1'b0;
        raise(46'h0000_0000_000f);
        tick(2);
        `CHK("pin level", 5'h04, irq_level)
        take_seq(67, -1, 4, -1, 4);
    endtask
    task automatic scen_periph;
        wr(4'h1, 32'h0000_7000);
        accept_en <= 1'b0;
        raise(46'h0000_0000_01f0);
        tick(2);
        `CHK("shared level", 5'h07, irq_level)
        take_seq(88, 1, 7, 0, 4);
        tick(3);
        `CHK("level zero", 1'b0, irq_to_core)
    endtask
    task automatic scen_fixed;
        wr(4'h9, 32'h0000_000f);
        nmi_request <= 1'b1;
        break_match <= 1'b1;
        wait_take(8'h0b, 4'hf);
        tick(3);
        `CHK("break level", 5'h0f, irq_level)
        wr(4'h9, 32'h0000_000e);
        wait_take(8'h0c, 4'hf);
        wr(4'h9, 32'h0000_0000);
        tick(4);
        `CHK("break once", 1'b0, irq_to_core)
        @(posedge clk);
        nmi_request <= 1'b0;
        break_match <= 1'b0;
    endtask
    task automatic scen_slow;
        latency <= 4'h5;
        wr(4'h8, 32'h0000_f000);
        raise(46'h2000_0000_0000);
        wait_take(8'hc8, 4'hf);
        `CHK("table addr", 32'h0000_0320, vector_addr)
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        scen_regs();
        scen_pins();
        scen_periph();
        scen_fixed();
        scen_slow();
        conclude();
    end
endmodule // testbench
`default_nettype wire
